/* File: hw/line_scan_trigger.sv */
// line trigger, exposure sequencing, link output and status lamp
// assumes sensor_pixel and configuration inputs are on sys_clk;
// line_trigger arrives from the link and is synchronised here
// ----------------------------------------------------------------
// Overview of operation
// - external mode: trigger falling edge starts readout
// - default configuration uses internal trigger and exposure
// - width mode: trigger high time is exposure
// - measure trigger period, even for ignored triggers
// - act on triggers no faster than 48 kHz
// - lval spans valid line; dval, fval unused
// - pixel data stable at strobe rising edge
// - lamp shows only highest priority condition
// - lamp off, blinking green, green, red meanings
// - ramp pattern r 0, g 102, b 204
// - internal mode: line timer plus exposure timer
// ----------------------------------------------------------------
`timescale 1ns/1ns
`include "lst_map.svh"
module line_scan_trigger
  import lst_pkg::*;
#(
  parameter int BLINK_HALF_CYC = `BLINK_HALF_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic line_trigger,
  input wire logic ext_trig_en,
  input wire logic width_exposure,
  input wire logic test_ramp_en,
  input wire logic [23:0] line_period_cfg,
  input wire logic [23:0] exposure_cfg,
  input wire logic [23:0] sensor_pixel,
  input wire logic powering_up,
  input wire logic calibrating,
  input wire logic hw_fault,
  input wire logic [7:0] fault_flags,
  input wire logic [7:0] fault_clear,
  output logic lval,
  output logic dval,
  output logic fval,
  output logic strobe,
  output logic [23:0] pix_data,
  output logic integrating,
  output logic [23:0] trig_period,
  output logic trig_period_valid,
  output logic [23:0] exposure_meas,
  output logic [7:0] self_test_result,
  output logic lamp_red,
  output logic lamp_green
);
  top_state_t st_reg;
  top_state_t st_next;
  pix_fifo_if #(.WIDTH(`FIFO_WIDTH)) fq ();

  logic trig_fall;
  logic trig_rise;
  logic tmr_fire;
  logic act;
  logic [7:0] ramp_r;

  pix_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .bus(fq.fifo)
  );

  // ----------------------------------------------------------------
  // trigger edges and acceptance
  // ----------------------------------------------------------------
  assign trig_fall = !st_reg.trig_s2 && st_reg.trig_d;
  assign trig_rise = st_reg.trig_s2 && !st_reg.trig_d;
  assign tmr_fire = (st_reg.line_tmr == '0);
  // busy lines drop new triggers; the period is still measured
  assign act = (st_reg.seq == S_IDLE) && (st_reg.holdoff == '0) &&
               (ext_trig_en ? trig_fall : tmr_fire);

  assign ramp_r = `RAMP_R_START + st_reg.pix[7:0];
  assign fq.push_valid = (st_reg.seq == S_READ);
  // 8-bit sums wrap past 255 by width
  assign fq.push_data = {st_reg.pix == 13'(`LINE_PIXELS - 1),
                         test_ramp_en ? {ramp_r, 8'(ramp_r + `RAMP_G_START),
                         8'(ramp_r + `RAMP_B_START)} : sensor_pixel};
  // hold the gap after a line end so lval drops between lines
  assign fq.pop_ready = st_reg.strobe && !(st_reg.lval && st_reg.last_shown);

  always_comb begin
    st_next = st_reg;
    st_next.trig_s1 = line_trigger;
    st_next.trig_s2 = st_reg.trig_s1;
    st_next.trig_d = st_reg.trig_s2;

    // ----------------------------------------------------------------
    // period and high-time measurement
    // ----------------------------------------------------------------
    if (st_reg.period_cnt != '1) begin
      st_next.period_cnt = st_reg.period_cnt + 24'h000001;
    end
    if (trig_fall) begin
      st_next.period_cnt = 24'h000001;
      st_next.armed = 1'b1;
      st_next.trig_period = st_reg.period_cnt;
      st_next.period_valid = st_reg.armed;
      st_next.exposure_meas = st_reg.high_cnt;
    end
    if (trig_rise) begin
      st_next.high_cnt = 24'h000001;
    end else if (st_reg.trig_s2 && st_reg.high_cnt != '1) begin
      st_next.high_cnt = st_reg.high_cnt + 24'h000001;
    end

    // ----------------------------------------------------------------
    // line sequencing
    // ----------------------------------------------------------------
    if (st_reg.holdoff != '0) begin
      st_next.holdoff = st_reg.holdoff - 11'h001;
    end
    if (tmr_fire) begin
      st_next.line_tmr = (line_period_cfg == '0) ? '0 :
                         line_period_cfg - 24'h000001;
    end else begin
      st_next.line_tmr = st_reg.line_tmr - 24'h000001;
    end
    if (act) begin
      st_next.holdoff = 11'(`TRIG_HOLDOFF_CYC - 1);
    end
    unique case (st_reg.seq)
      S_IDLE: begin
        st_next.pix = '0;
        if (act && ext_trig_en) begin
          st_next.seq = S_READ;
        end else if (act) begin
          st_next.exp_cnt = exposure_cfg;
          st_next.seq = S_EXPOSE;
        end
      end
      S_EXPOSE: begin
        st_next.exp_cnt = st_reg.exp_cnt - 24'h000001;
        if (st_reg.exp_cnt <= 24'h000001) begin
          st_next.seq = S_READ;
        end
      end
      S_READ: begin
        if (fq.push_ready) begin
          st_next.pix = st_reg.pix + 13'h0001;
          if (st_reg.pix == 13'(`LINE_PIXELS - 1)) begin
            st_next.seq = S_IDLE;
          end
        end
      end
      default: begin
        st_next.seq = S_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // link output: data change on strobe fall, held over its rise
    // ----------------------------------------------------------------
    st_next.strobe = !st_reg.strobe;
    if (fq.pop_valid && fq.pop_ready) begin
      st_next.pix_data = fq.pop_data[23:0];
      st_next.last_shown = fq.pop_data[24];
      st_next.lval = 1'b1;
    end else if (st_reg.strobe) begin
      st_next.lval = 1'b0;
      st_next.last_shown = 1'b0;
    end

    // ----------------------------------------------------------------
    // self-test result and status lamp
    // ----------------------------------------------------------------
    // a fault in the clear cycle survives
    st_next.self_test = (st_reg.self_test & ~fault_clear) | fault_flags;
    if (st_reg.blink_cnt >= 24'(BLINK_HALF_CYC - 1)) begin
      st_next.blink_cnt = '0;
      st_next.blink = !st_reg.blink;
    end else begin
      st_next.blink_cnt = st_reg.blink_cnt + 24'h000001;
    end
    if (hw_fault) begin
      st_next.lamp_red = 1'b0;
      st_next.lamp_green = 1'b0;
    end else if (st_reg.self_test != '0) begin
      st_next.lamp_red = 1'b1;
      st_next.lamp_green = 1'b0;
    end else if (powering_up || calibrating) begin
      st_next.lamp_red = 1'b0;
      st_next.lamp_green = st_reg.blink;
    end else begin
      st_next.lamp_red = 1'b0;
      st_next.lamp_green = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign lval = st_reg.lval;
  // no meaning on this link; held low
  assign dval = 1'b0;
  assign fval = 1'b0;
  assign strobe = st_reg.strobe;
  assign pix_data = st_reg.pix_data;
  assign integrating = (st_reg.seq == S_EXPOSE) ||
                       (ext_trig_en && width_exposure && st_reg.trig_s2);
  assign trig_period = st_reg.trig_period;
  assign trig_period_valid = st_reg.period_valid;
  assign exposure_meas = st_reg.exposure_meas;
  assign self_test_result = st_reg.self_test;
  assign lamp_red = st_reg.lamp_red;
  assign lamp_green = st_reg.lamp_green;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_fall_starts_read: assert property (
    ext_trig_en && trig_fall && st_reg.seq == S_IDLE && st_reg.holdoff == '0
    |=> st_reg.seq == S_READ) else $error("falling trigger did not start readout");
  a_internal_ignores_pin: assert property (
    !ext_trig_en && trig_fall && !tmr_fire |-> !act)
    else $error("pin trigger acted in internal mode");
  a_width_captured: assert property (
    trig_fall |=> exposure_meas == $past(st_reg.high_cnt))
    else $error("trigger high time not captured");
  a_period_captured: assert property (
    trig_fall |=> trig_period == $past(st_reg.period_cnt) && st_reg.period_cnt == 24'h000001)
    else $error("trigger period not captured");
  a_rate_holdoff: assert property (
    act |=> st_reg.holdoff == 11'(`TRIG_HOLDOFF_CYC - 1) && !act)
    else $error("triggers acted too close together");
  a_lval_drop_last: assert property (
    $fell(lval) |-> $past(st_reg.last_shown) && !dval && !fval)
    else $error("lval fell before line end");
  a_data_at_rise: assert property (
    $rose(strobe) |-> $stable(pix_data)) else $error("data changed at strobe rise");
  a_error_red: assert property (
    !hw_fault && st_reg.self_test != '0 |=> lamp_red && !lamp_green)
    else $error("error not shown red");
  a_ready_green: assert property (
    !hw_fault && st_reg.self_test == '0 && !powering_up && !calibrating
    |=> lamp_green && !lamp_red) else $error("ready not shown green");
  a_ramp_offsets: assert property (
    fq.push_valid && test_ramp_en |-> fq.push_data[15:8] == 8'(fq.push_data[23:16] +
    `RAMP_G_START) && fq.push_data[7:0] == 8'(fq.push_data[23:16] + `RAMP_B_START))
    else $error("ramp offsets wrong");
  a_expose_then_read: assert property (
    st_reg.seq == S_EXPOSE && st_reg.exp_cnt <= 24'h000001 |=> st_reg.seq == S_READ)
    else $error("exposure did not end in readout");
endmodule

/* File: hw/lst_map.svh */
// constants for the line scan trigger and output block
// assumes a 50 MHz sys_clk; all cycle counts are derived from that rate
`ifndef LST_MAP_SVH
`define LST_MAP_SVH

`define CLK_HZ 50000000
// fastest line trigger the block acts on, in Hz
`define MAX_TRIG_HZ 48000
// least spacing between two acted triggers, rounded up
`define TRIG_HOLDOFF_CYC ((`CLK_HZ + `MAX_TRIG_HZ - 1) / `MAX_TRIG_HZ)
// period measurement resolution required, in ns; sys_clk gives 20 ns
`define PERIOD_RES_NS 25
`define LINE_PIXELS 8192
`define RAMP_R_START 8'h00
`define RAMP_G_START 8'h66
`define RAMP_B_START 8'hcc
`define FIFO_DEPTH 8
`define FIFO_WIDTH 25
// half period of the blinking green lamp, in ms
`define BLINK_HALF_MS 250
`define BLINK_HALF_CYC ((`CLK_HZ / 1000) * `BLINK_HALF_MS)

`endif

/* File: hw/lst_pkg.sv */
// types for the line scan trigger and output block
// assumes lst_map.svh constants; no clocked logic here
package lst_pkg;

  typedef enum logic [1:0] {S_IDLE, S_EXPOSE, S_READ} seq_state_t;

  typedef struct packed {
    logic trig_s1;
    logic trig_s2;
    logic trig_d;
    logic armed;
    logic [23:0] period_cnt;
    logic [23:0] trig_period;
    logic period_valid;
    logic [23:0] high_cnt;
    logic [23:0] exposure_meas;
    logic [10:0] holdoff;
    logic [23:0] line_tmr;
    logic [23:0] exp_cnt;
    seq_state_t seq;
    logic [12:0] pix;
    logic strobe;
    logic lval;
    logic last_shown;
    logic [23:0] pix_data;
    logic [23:0] blink_cnt;
    logic blink;
    logic [7:0] self_test;
    logic lamp_red;
    logic lamp_green;
  } top_state_t;

endpackage

/* File: hw/pix_fifo_if.sv */
// carrier between the line sequencer and the pixel fifo
// assumes both ends run on sys_clk
`timescale 1ns/1ns
interface pix_fifo_if #(parameter int WIDTH = 25);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  modport fifo (input push_valid, push_data, pop_ready,
                output push_ready, pop_valid, pop_data);
  modport user (output push_valid, push_data, pop_ready,
                input push_ready, pop_valid, pop_data);
endinterface

/* File: hw/pix_fifo.sv */
// small pixel fifo between line readout and the strobe-paced output
// assumes one clock domain; pop data come straight from storage flops
`timescale 1ns/1ns
module pix_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  pix_fifo_if.fifo bus
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic do_push;
  logic do_pop;

  assign bus.push_ready = (st_reg.count != (AW+1)'(DEPTH));
  assign bus.pop_valid = (st_reg.count != '0);
  assign bus.pop_data = st_reg.mem[st_reg.rd];
  assign do_push = bus.push_valid & bus.push_ready;
  assign do_pop = bus.pop_valid & bus.pop_ready;

  always_comb begin
    st_next = st_reg;
    if (do_push) begin
      st_next.mem[st_reg.wr] = bus.push_data;
      st_next.wr = (st_reg.wr == AW'(DEPTH-1)) ? '0 : st_reg.wr + 1'b1;
    end
    if (do_pop) begin
      st_next.rd = (st_reg.rd == AW'(DEPTH-1)) ? '0 : st_reg.rd + 1'b1;
    end
    st_next.count = st_reg.count + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  a_fifo_count_bound: assert property (@(posedge sys_clk) disable iff (!rstn)
    st_reg.count <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule

/* File: tb/grabber_model.sv */
// frame grabber stand-in: shapes line trigger pulses, checks each pixel
// assumes the bench gates link_clk and freezes sensor_ref while the ramp is off
`timescale 1ns/1ns
module grabber_model (
  input wire logic link_clk,
  input wire logic lval,
  input wire logic strobe,
  input wire logic [23:0] pix_data,
  input wire logic ramp_on,
  input wire logic [23:0] sensor_ref,
  output logic line_trigger,
  output int lines,
  output int bad
);
  int idx;
  logic [23:0] want;
  initial begin
    line_trigger = 1'b0;
    lines = 0;
    bad = 0;
    idx = 0;
  end
  // high time is the exposure, the fall asks for readout
  task automatic pulse(input int high_cyc);
    @(posedge link_clk);
    line_trigger <= 1'b1;
    repeat (high_cyc) @(posedge link_clk);
    line_trigger <= 1'b0;
  endtask
  // sampled on strobe rising edges only, as a receiver would
  always @(posedge strobe) begin
    if (lval) begin
      want = ramp_on ? {idx[7:0], idx[7:0] + 8'h66, idx[7:0] + 8'hcc} : sensor_ref;
      if (pix_data !== want) bad = bad + 1;
      idx = idx + 1;
    end
  end
  // zero-pixel lines are not counted; the reset-time fall would fake one
  always @(negedge lval) begin
    if (idx != 0) begin
      if (idx != 8192) bad = bad + 1;
      lines = lines + 1;
      idx = 0;
    end
  end
endmodule

/* File: tb/tb_line_scan_trigger.sv */
// bench for the line trigger, readout and lamp block
// assumes lst_map.svh on the include path; link clock gated by link_run
`timescale 1ns/1ns
module tb_line_scan_trigger;
  logic sys_clk, rstn, link_clk, link_run, line_trigger;
  logic ext_trig_en, width_exposure, test_ramp_en, powering_up, calibrating, hw_fault;
  logic [23:0] line_period_cfg, exposure_cfg, sensor_pixel, pix_data, trig_period, exposure_meas;
  logic [7:0] fault_flags, fault_clear, self_test_result;
  logic lval, dval, fval, strobe, integrating, trig_period_valid, lamp_red, lamp_green;
  int lines, bad, n_errors, num_checks;

  line_scan_trigger #(.BLINK_HALF_CYC(8)) DUT (
    .sys_clk(sys_clk), .rstn(rstn), .line_trigger(line_trigger),
    .ext_trig_en(ext_trig_en), .width_exposure(width_exposure),
    .test_ramp_en(test_ramp_en), .line_period_cfg(line_period_cfg),
    .exposure_cfg(exposure_cfg), .sensor_pixel(sensor_pixel),
    .powering_up(powering_up), .calibrating(calibrating), .hw_fault(hw_fault),
    .fault_flags(fault_flags), .fault_clear(fault_clear), .lval(lval), .dval(dval),
    .fval(fval), .strobe(strobe), .pix_data(pix_data), .integrating(integrating),
    .trig_period(trig_period), .trig_period_valid(trig_period_valid),
    .exposure_meas(exposure_meas), .self_test_result(self_test_result),
    .lamp_red(lamp_red), .lamp_green(lamp_green)
  );
  grabber_model grab (
    .link_clk(link_clk), .lval(lval), .strobe(strobe), .pix_data(pix_data),
    .ramp_on(test_ramp_en), .sensor_ref(sensor_pixel),
    .line_trigger(line_trigger), .lines(lines), .bad(bad)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // odd offset keeps the link clock out of phase with sys_clk
  initial begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = link_run ? ~link_clk : 1'b0;
  end
  // moves under the ramp so a leak would show; frozen otherwise so pixels are known
  always @(posedge sys_clk) if (test_ramp_en) sensor_pixel <= sensor_pixel + 24'h1;

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic give_up(input int got, input int exp);
    n_errors++;
    $display("ERROR t=%0t wait ran out got=%h exp=%h", $time, got, exp);
    conclude();
  endtask
  task automatic wait_lines(input int n);
    int k;
    k = 0;
    while (lines < n && k < 40000) begin
      @(posedge sys_clk);
      k++;
    end
    if (lines < n) give_up(lines, n);
  endtask
  task automatic wait_lval(input logic v);
    int k;
    k = 0;
    while (lval !== v && k < 4000) begin
      @(posedge sys_clk);
      k++;
    end
    if (lval !== v) give_up(lval, v);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_lamp();
    int t;
    logic p;
    t = 0;
    p = lamp_green;
    powering_up <= 1'b1;
    repeat (64) begin
      @(posedge sys_clk);
      if (lamp_green !== p) t++;
      p = lamp_green;
    end
    check(24'(t > 4), 24'h1);
    calibrating <= 1'b1;
    fault_flags <= 8'h04;
    @(posedge sys_clk);
    fault_flags <= 8'h00;
    repeat (3) @(posedge sys_clk);
    check(self_test_result, 24'h04);
    check({lamp_red, lamp_green}, 24'h2);
    fault_clear <= 8'h04;
    powering_up <= 1'b0;
    calibrating <= 1'b0;
    @(posedge sys_clk);
    fault_clear <= 8'h00;
    repeat (3) @(posedge sys_clk);
    check(self_test_result, 24'h0);
    check({lamp_red, lamp_green}, 24'h1);
    hw_fault <= 1'b1;
    fault_flags <= 8'h01;
    repeat (3) @(posedge sys_clk);
    check({lamp_red, lamp_green}, 24'h0);
    hw_fault <= 1'b0;
    fault_flags <= 8'h00;
    fault_clear <= 8'h01;
    @(posedge sys_clk);
    fault_clear <= 8'h00;
  endtask
  task automatic t_internal();
    int n;
    check({dval, fval}, 24'h0);
    link_run = 1'b1;
    grab.pulse(2);
    link_run = 1'b0;
    repeat (10) @(posedge sys_clk);
    check(exposure_meas, 24'd16);
    wait_lines(1);
    wait_lval(1'b1);
    ext_trig_en <= 1'b1;
    wait_lines(2);
    n = lines;
    repeat (3000) @(posedge sys_clk);
    check(lines, n);
    check(bad, 24'h0);
  endtask
  task automatic t_ext();
    int n;
    n = lines;
    link_run = 1'b1;
    grab.pulse(4);
    repeat (10) @(posedge link_clk);
    grab.pulse(4);
    link_run = 1'b0;
    repeat (20) @(posedge sys_clk);
    check(lval, 24'h1);
    check(trig_period, 24'd120);
    check(trig_period_valid, 24'h1);
    check(exposure_meas, 24'd32);
    wait_lines(n + 1);
    repeat (2000) @(posedge sys_clk);
    check(lines, n + 1);
  endtask
  task automatic t_width();
    int n;
    n = lines;
    width_exposure <= 1'b1;
    test_ramp_en <= 1'b0;
    link_run = 1'b1;
    fork
      grab.pulse(20);
      begin
        repeat (60) @(posedge sys_clk);
        check(integrating, 24'h1);
      end
    join
    link_run = 1'b0;
    repeat (10) @(posedge sys_clk);
    check(exposure_meas, 24'd160);
    wait_lines(n + 1);
    check(integrating, 24'h0);
    check(bad, 24'h0);
  endtask

  initial begin
    n_errors = 0;
    num_checks = 0;
    rstn = 1'b0;
    link_run = 1'b0;
    ext_trig_en = 1'b0;
    width_exposure = 1'b0;
    test_ramp_en = 1'b1;
    line_period_cfg = 24'h000400;
    exposure_cfg = 24'h000020;
    sensor_pixel = 24'h0;
    powering_up = 1'b0;
    calibrating = 1'b0;
    hw_fault = 1'b0;
    fault_flags = 8'h00;
    fault_clear = 8'h00;
    repeat (12) @(posedge sys_clk);
    check({lval, strobe, lamp_red, lamp_green}, 24'h0);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_lamp();
    t_internal();
    t_ext();
    t_width();
    conclude();
  end
endmodule
